/* File: cmpctl_analog_model.sv */
// Behavioural model of the analog comparator and amplifier
module cmpctl_analog_model (
   // Control from the block
   input  wire logic        clk_in,
   input  wire logic        cmp_en_in,
   input  wire logic        minus_sel_in,
   input  wire logic        amp_oe_in,
   // Analog levels set by the bench
   input  wire logic [15:0] plus_mv_in,
   input  wire logic [15:0] b6_mv_in,
   input  wire logic [15:0] c0_mv_in,
   input  wire logic        amp_level_in,
   // Raw outputs
   output logic             cmp_raw_out,
   output logic             amp_raw_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic       junk = 1'b0;
   wire [15:0] minus_mv = minus_sel_in ? c0_mv_in : b6_mv_in;
   // Unpowered outputs carry garbage, so gating in the block is exercised
   always @(posedge clk_in) junk <= !junk;
   assign cmp_raw_out = cmp_en_in ? (plus_mv_in > minus_mv) : junk;
   assign amp_raw_out = amp_oe_in ? amp_level_in : junk;
endmodule

/* File: cmpctl_monitor.sv */
// Assertion checker for the comparator and amplifier control block
module cmpctl_monitor #(
   parameter int unsigned CHAN_W = 4
) (
   // Clock, reset and enable
   input wire logic              clk_sys_in,
   input wire logic              arst_n_in,
   input wire logic              ce_in,
   // Register bus
   input wire logic              hsel_in,
   input wire logic [31:0]       haddr_in,
   input wire logic [1:0]        htrans_in,
   input wire logic              hwrite_in,
   input wire logic [2:0]        hsize_in,
   input wire logic              hready_in,
   input wire logic [31:0]       hwdata_in,
   input wire logic              hreadyout_out,
   input wire logic              hresp_out,
   input wire logic [31:0]       hrdata_out,
   // Comparator and amplifier
   input wire logic              cmp_raw_in,
   input wire logic              cmp_enable_out,
   input wire logic              cmp_minus_source_select_out,
   input wire logic              fault_out,
   input wire logic              cmp_irq_out,
   input wire logic              amp_raw_in,
   input wire logic              amp_enable_out,
   input wire logic              amp_output_pin_oe_out,
   // Routing
   input wire logic              port3_schmitt_en_in,
   input wire logic [CHAN_W-1:0] adc_chan_sel_in,
   input wire logic              port3_amp_data_out,
   input wire logic              portb3_irq_src_out,
   input wire logic              converter_channel_three_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic       wr_pend;
   logic       rd_pend;
   logic       un_pend;
   logic [7:0] shadow;
   wire logic  take = hsel_in && hready_in && ce_in && htrans_in == cmpctl_pkg::HTRANS_NONSEQ;
   wire logic  hit  = haddr_in == cmpctl_pkg::CTRL_ADDR;
   default clocking @(posedge clk_sys_in); endclocking
   default disable iff (!arst_n_in);
   // Shadow of the writable fields; reserved and status bits masked out
   always_ff @(posedge clk_sys_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         wr_pend <= 1'b0;
         rd_pend <= 1'b0;
         un_pend <= 1'b0;
         shadow  <= 8'h00;
      end
      else
      begin
         wr_pend <= take && hwrite_in && hit;
         rd_pend <= take && !hwrite_in && hit;
         un_pend <= take && !hwrite_in && !hit;
         if (wr_pend)
            shadow <= hwdata_in[7:0] & 8'h9d;
      end
   end
   // Register fields reach the outputs
   amp_enable_a: assert property (amp_enable_out == shadow[7] && amp_output_pin_oe_out == shadow[7])
      else $error("amplifier enable differs from control bit");
   cmp_fields_a: assert property (cmp_enable_out == shadow[0] && cmp_minus_source_select_out == shadow[4])
      else $error("comparator fields differ from control bits");
   // Interrupt edges, fault level and disabled outputs
   irq_rise_a: assert property (cmp_enable_out && !shadow[3] && $rose(cmp_raw_in) |-> ##[1:3] cmp_irq_out)
      else $error("no request after rising comparator");
   irq_fall_a: assert property (cmp_enable_out && shadow[3] && $fell(cmp_raw_in) |-> ##[1:3] cmp_irq_out)
      else $error("no request after falling comparator");
   irq_pulse_a: assert property (cmp_irq_out |-> cmp_enable_out ##1 !cmp_irq_out)
      else $error("request longer than one cycle");
   fault_level_a: assert property ((cmp_enable_out && $stable(cmp_raw_in) && $stable(shadow)) [*4] |-> fault_out == (cmp_raw_in ^ shadow[2]))
      else $error("fault level wrong");
   cmp_off_a: assert property (!cmp_enable_out [*2] |-> !fault_out && !cmp_irq_out)
      else $error("comparator outputs active while disabled");
   // Read data
   read_back_a: assert property (rd_pend |-> hrdata_out[31:8] == 24'h0 && hrdata_out[6:5] == 2'h0 && (hrdata_out[7:0] & 8'h9d) == shadow)
      else $error("control read data wrong");
   unmapped_a: assert property (un_pend |-> hrdata_out == 32'h0)
      else $error("unmapped read not zero");
   // Amplifier routing
   amp_route_a: assert property (port3_amp_data_out || portb3_irq_src_out |-> amp_enable_out || $past(amp_enable_out))
      else $error("amplifier level routed while disabled");
   adc_route_a: assert property (($stable(adc_chan_sel_in) && $stable(amp_enable_out)) [*2] |-> converter_channel_three_out == (amp_enable_out && adc_chan_sel_in == CHAN_W'(cmpctl_pkg::AMP_ADC_CHAN)))
      else $error("converter channel route wrong");
endmodule
bind cmpctl_top cmpctl_monitor #(.CHAN_W(CHAN_W)) u_mon (.*);

/* File: cmpctl_pkg.sv */
// Constants and field layout for the comparator and amplifier control block
package cmpctl_pkg;
   // -------------------------------------------------------------
   // Register map
   // -------------------------------------------------------------
   localparam logic [31:0] CTRL_ADDR  = 32'h00ffe510;
   localparam logic [7:0]  CTRL_RESET = 8'h00;

   // -------------------------------------------------------------
   // Field positions in the control register
   // -------------------------------------------------------------
   localparam int unsigned AMP_EN_BIT     = 7;
   localparam int unsigned RSVD_HI_BIT    = 6;
   localparam int unsigned RSVD_LO_BIT    = 5;
   localparam int unsigned MINUS_SEL_BIT  = 4;
   localparam int unsigned EDGE_SEL_BIT   = 3;
   localparam int unsigned POLARITY_BIT   = 2;
   localparam int unsigned CMP_OUT_BIT    = 1;
   localparam int unsigned CMP_EN_BIT     = 0;

   // -------------------------------------------------------------
   // Signal routing
   // -------------------------------------------------------------
   localparam int unsigned  SYNC_CMP      = 0;
   localparam int unsigned  SYNC_AMP      = 1;
   localparam int unsigned  SYNC_CHANNELS = 2;
   localparam logic [3:0]   AMP_ADC_CHAN  = 4'h3;

   // -------------------------------------------------------------
   // Bus encodings
   // -------------------------------------------------------------
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic       HRESP_OKAY    = 1'h0;
endpackage

/* File: cmpctl_sync.sv */
// Two-flop synchroniser with edge pulses for asynchronous analog outputs
module cmpctl_sync #(
   parameter int unsigned N = 2
) (
   // Clock, reset and enable
   input  wire logic clk_in,
   input  wire logic rst_n_in,
   input  wire logic ce_in,
   // Synchronised signals
   cmpctl_sync_if.sync port
);
   genvar i;

   // -------------------------------------------------------------
   // Per-channel synchroniser
   // -------------------------------------------------------------
   generate
      for (i = 0; i < N; i++)
      begin : g_chan
         logic meta;
         logic stable;
         logic last;

         // First flop feeds only the second; edges come from later copies
         always_ff @(posedge clk_in or negedge rst_n_in)
         begin
            if (!rst_n_in)
            begin
               meta   <= 1'b0;
               stable <= 1'b0;
               last   <= 1'b0;
            end
            else if (ce_in)
            begin
               meta   <= port.raw[i];
               stable <= meta;
               last   <= stable;
            end
         end

         // Both directions detected so the user picks one later
         assign port.level[i] = stable;
         assign port.rise[i]  = stable & ~last;
         assign port.fall[i]  = ~stable & last;
      end
   endgenerate
endmodule

/* File: cmpctl_sync_if.sv */
// Carrier between the control logic and the input synchroniser
interface cmpctl_sync_if #(parameter int unsigned N = 2);
   logic [N-1:0] raw;
   logic [N-1:0] level;
   logic [N-1:0] rise;
   logic [N-1:0] fall;

   // Synchroniser drives levels and edges from raw inputs
   modport sync (input raw, output level, output rise, output fall);
   // Control logic hands raw pins in and reads the results
   modport ctrl (output raw, input level, input rise, input fall);
endinterface

/* File: cmpctl_top.sv */
// Control and status logic around the on-chip comparator and amplifier
//
// The implementer's own choice: register access over AHB-Lite.
module cmpctl_top #(
   parameter int unsigned CHAN_W = 4
) (
   // Clock, reset and enable
   input  wire logic              clk_sys_in,
   input  wire logic              arst_n_in,
   input  wire logic              ce_in,
   // AHB-Lite slave
   input  wire logic              hsel_in,
   input  wire logic [31:0]       haddr_in,
   input  wire logic [1:0]        htrans_in,
   input  wire logic              hwrite_in,
   input  wire logic [2:0]        hsize_in,
   input  wire logic              hready_in,
   input  wire logic [31:0]       hwdata_in,
   output logic                   hreadyout_out,
   output logic                   hresp_out,
   output logic [31:0]            hrdata_out,
   // Analog comparator
   input  wire logic              cmp_raw_in,
   output logic                   cmp_enable_out,
   output logic                   cmp_minus_source_select_out,
   output logic                   fault_out,
   output logic                   cmp_irq_out,
   // Operational amplifier
   input  wire logic              amp_raw_in,
   output logic                   amp_enable_out,
   output logic                   amp_output_pin_oe_out,
   // Port and converter routing
   input  wire logic              port3_schmitt_en_in,
   input  wire logic [CHAN_W-1:0] adc_chan_sel_in,
   output logic                   port3_amp_data_out,
   output logic                   portb3_irq_src_out,
   output logic                   converter_channel_three_out
);
   // -------------------------------------------------------------
   // Reset release
   // -------------------------------------------------------------
   logic rst_meta;
   logic rst_n;

   // Asynchronous assert, release after two clean edges
   // Release is synchronous so no flop sees reset drop near its edge
   always_ff @(posedge clk_sys_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         rst_meta <= 1'b0;
         rst_n    <= 1'b0;
      end
      else
      begin
         rst_meta <= 1'b1;
         rst_n    <= rst_meta;
      end
   end

   // -------------------------------------------------------------
   // Input synchronisers
   // -------------------------------------------------------------
   cmpctl_sync_if #(.N(cmpctl_pkg::SYNC_CHANNELS)) sync_bus ();

   // Pins from the analog side are asynchronous to clk_sys_in
   assign sync_bus.raw[cmpctl_pkg::SYNC_CMP] = cmp_raw_in;
   assign sync_bus.raw[cmpctl_pkg::SYNC_AMP] = amp_raw_in;

   cmpctl_sync #(
      .N        (cmpctl_pkg::SYNC_CHANNELS)
   ) u_sync (
      .clk_in   (clk_sys_in),
      .rst_n_in (rst_n),
      .ce_in    (ce_in),
      .port     (sync_bus.sync)
   );

   // Synchronised copies; only these are read by the logic below
   logic cmp_level;
   logic cmp_rise;
   logic cmp_fall;
   logic amp_level;

   // Comparator is high when plus exceeds minus, used after two flops
   assign cmp_level = sync_bus.level[cmpctl_pkg::SYNC_CMP];
   assign cmp_rise  = sync_bus.rise[cmpctl_pkg::SYNC_CMP];
   assign cmp_fall  = sync_bus.fall[cmpctl_pkg::SYNC_CMP];
   assign amp_level = sync_bus.level[cmpctl_pkg::SYNC_AMP];

   // -------------------------------------------------------------
   // Control register fields
   // -------------------------------------------------------------
   logic amp_en;
   logic minus_sel;
   logic edge_sel;
   logic polarity;
   logic cmp_en;

   // -------------------------------------------------------------
   // Bus address phase decode
   // -------------------------------------------------------------
   logic addr_phase;
   logic ctrl_hit;
   logic wr_req;
   logic rd_req;

   // Only NONSEQ is taken; IDLE and BUSY give no access
   assign addr_phase = hsel_in & hready_in & (htrans_in == cmpctl_pkg::HTRANS_NONSEQ);
   assign ctrl_hit   = (haddr_in == cmpctl_pkg::CTRL_ADDR);
   assign wr_req     = addr_phase & hwrite_in & ctrl_hit;
   assign rd_req     = addr_phase & ~hwrite_in;

   // -------------------------------------------------------------
   // Data phase write strobe
   // -------------------------------------------------------------
   logic wr_pend;

   // Write data arrives one cycle after the address is taken
   // Unmapped writes never raise the strobe, so they leave no trace
   always_ff @(posedge clk_sys_in or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wr_pend <= 1'b0;
      end
      else if (ce_in)
      begin
         wr_pend <= wr_req;
      end
   end

   // -------------------------------------------------------------
   // Write data fields
   // -------------------------------------------------------------
   logic wd_amp_en;
   logic wd_minus_sel;
   logic wd_edge_sel;
   logic wd_polarity;
   logic wd_cmp_en;

   // Slices of the data phase word; bits 6, 5 and 1 are never stored
   assign wd_amp_en    = hwdata_in[cmpctl_pkg::AMP_EN_BIT];
   assign wd_minus_sel = hwdata_in[cmpctl_pkg::MINUS_SEL_BIT];
   assign wd_edge_sel  = hwdata_in[cmpctl_pkg::EDGE_SEL_BIT];
   assign wd_polarity  = hwdata_in[cmpctl_pkg::POLARITY_BIT];
   assign wd_cmp_en    = hwdata_in[cmpctl_pkg::CMP_EN_BIT];

   // -------------------------------------------------------------
   // Next register values
   // -------------------------------------------------------------
   logic next_amp_en;
   logic next_minus_sel;
   logic next_edge_sel;
   logic next_polarity;
   logic next_cmp_en;

   // Bit 7 changes only by software; no hardware path clears it
   assign next_amp_en    = wr_pend ? wd_amp_en : amp_en;
   assign next_minus_sel = wr_pend ? wd_minus_sel : minus_sel;
   assign next_edge_sel  = wr_pend ? wd_edge_sel : edge_sel;
   assign next_polarity  = wr_pend ? wd_polarity : polarity;
   assign next_cmp_en    = wr_pend ? wd_cmp_en : cmp_en;

   // Writable fields; bits 6, 5 and 1 have no storage at all
   always_ff @(posedge clk_sys_in or negedge rst_n)
   begin
      if (!rst_n)
      begin
         amp_en    <= cmpctl_pkg::CTRL_RESET[cmpctl_pkg::AMP_EN_BIT];
         minus_sel <= cmpctl_pkg::CTRL_RESET[cmpctl_pkg::MINUS_SEL_BIT];
         edge_sel  <= cmpctl_pkg::CTRL_RESET[cmpctl_pkg::EDGE_SEL_BIT];
         polarity  <= cmpctl_pkg::CTRL_RESET[cmpctl_pkg::POLARITY_BIT];
         cmp_en    <= cmpctl_pkg::CTRL_RESET[cmpctl_pkg::CMP_EN_BIT];
      end
      else if (ce_in)
      begin
         amp_en    <= next_amp_en;
         minus_sel <= next_minus_sel;
         edge_sel  <= next_edge_sel;
         polarity  <= next_polarity;
         cmp_en    <= next_cmp_en;
      end
   end

   // -------------------------------------------------------------
   // Read data
   // -------------------------------------------------------------
   logic [7:0]  ctrl_view;
   logic [31:0] next_hrdata;

   // Live comparator level on bit 1, reserved bits forced to zero
   always_comb
   begin
      ctrl_view                                 = 8'h00;
      ctrl_view[cmpctl_pkg::AMP_EN_BIT]         = amp_en;
      ctrl_view[cmpctl_pkg::MINUS_SEL_BIT]      = minus_sel;
      ctrl_view[cmpctl_pkg::EDGE_SEL_BIT]       = edge_sel;
      ctrl_view[cmpctl_pkg::POLARITY_BIT]       = polarity;
      ctrl_view[cmpctl_pkg::CMP_OUT_BIT]        = cmp_level;
      ctrl_view[cmpctl_pkg::CMP_EN_BIT]         = cmp_en;
   end

   // Unmapped reads return zero rather than aliasing the register
   assign next_hrdata = (rd_req & ctrl_hit) ? {24'h000000, ctrl_view} :
                        rd_req ? 32'h00000000 : hrdata_out;

   // -------------------------------------------------------------
   // Bus response
   // -------------------------------------------------------------
   // Zero wait states; read data is captured at the address edge
   always_ff @(posedge clk_sys_in or negedge rst_n)
   begin
      if (!rst_n)
      begin
         hrdata_out <= 32'h00000000;
      end
      else if (ce_in)
      begin
         hrdata_out <= next_hrdata;
      end
   end

   // Never stalls and never errors, so software sees a plain memory slot
   always_ff @(posedge clk_sys_in or negedge rst_n)
   begin
      if (!rst_n)
      begin
         hreadyout_out <= 1'b1;
         hresp_out     <= cmpctl_pkg::HRESP_OKAY;
      end
      else if (ce_in)
      begin
         hreadyout_out <= 1'b1;
         hresp_out     <= cmpctl_pkg::HRESP_OKAY;
      end
   end

   // -------------------------------------------------------------
   // Comparator event and fault logic
   // -------------------------------------------------------------
   logic cmp_edge;
   logic next_fault;
   logic next_cmp_irq;

   // Both edges come from the synchroniser; bit 3 keeps only one
   assign cmp_edge     = edge_sel ? cmp_fall : cmp_rise;
   // Pulses only while enabled; a disabled comparator may feed junk edges
   assign next_cmp_irq = cmp_en & cmp_edge;
   // A disabled comparator cannot fault the modulator
   assign next_fault   = cmp_en & (polarity ? ~cmp_level : cmp_level);

   // -------------------------------------------------------------
   // Amplifier routing
   // -------------------------------------------------------------
   logic next_port3;
   logic next_portb3;
   logic next_adc_route;

   // Outputs gated by the enable so a floating output reads low
   assign next_port3     = amp_en & port3_schmitt_en_in & amp_level;
   assign next_portb3    = amp_en & amp_level;
   // Channel three carries the amplifier only while it is powered
   assign next_adc_route = amp_en & (adc_chan_sel_in == CHAN_W'(cmpctl_pkg::AMP_ADC_CHAN));

   // -------------------------------------------------------------
   // Registered outputs to analog, modulator and ports
   // -------------------------------------------------------------
   // Each output lags its cause by one edge; the cost is one cycle
   always_ff @(posedge clk_sys_in or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cmp_enable_out              <= 1'b0;
         cmp_minus_source_select_out <= 1'b0;
         fault_out                   <= 1'b0;
         cmp_irq_out                 <= 1'b0;
      end
      else if (ce_in)
      begin
         cmp_enable_out              <= next_cmp_en;
         cmp_minus_source_select_out <= next_minus_sel;
         fault_out                   <= next_fault;
         cmp_irq_out                 <= next_cmp_irq;
      end
   end

   // Power and drive follow bit 7 together, so an unpowered amp never drives
   always_ff @(posedge clk_sys_in or negedge rst_n)
   begin
      if (!rst_n)
      begin
         amp_enable_out              <= 1'b0;
         amp_output_pin_oe_out       <= 1'b0;
      end
      else if (ce_in)
      begin
         amp_enable_out              <= next_amp_en;
         amp_output_pin_oe_out       <= next_amp_en;
      end
   end

   // Port copies of the amplifier level and the converter channel three route
   always_ff @(posedge clk_sys_in or negedge rst_n)
   begin
      if (!rst_n)
      begin
         port3_amp_data_out          <= 1'b0;
         portb3_irq_src_out          <= 1'b0;
         converter_channel_three_out <= 1'b0;
      end
      else if (ce_in)
      begin
         port3_amp_data_out          <= next_port3;
         portb3_irq_src_out          <= next_portb3;
         converter_channel_three_out <= next_adc_route;
      end
   end

   // -------------------------------------------------------------
   // Unused bus qualifiers
   // -------------------------------------------------------------
   // Only whole-word transfers are expected, so the size is not checked
   logic unused_size;
   assign unused_size = ^hsize_in;
endmodule

/* File: testbench.sv */
// Self-checking bench for the comparator and amplifier control block
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [31:0] CTRL = cmpctl_pkg::CTRL_ADDR;
   logic clk_sys_in = 0, arst_n_in = 0, ce_in = 1, hsel_in = 0, hwrite_in = 0;
   logic [31:0] haddr_in = '0, hwdata_in = '0, hrdata_out;
   logic [1:0] htrans_in = '0;
   logic [2:0] hsize_in = 3'h2;
   logic [3:0] adc_chan_sel_in = '0;
   logic port3_schmitt_en_in = 0, amp_level = 0, cmp_raw_in, amp_raw_in;
   logic [15:0] plus_mv = 16'd100, b6_mv = 16'd200, c0_mv = 16'd50;
   logic hreadyout_out, hresp_out, cmp_enable_out, cmp_minus_source_select_out, fault_out;
   logic cmp_irq_out, amp_enable_out, amp_output_pin_oe_out;
   logic port3_amp_data_out, portb3_irq_src_out, converter_channel_three_out;
   wire logic hready_in = hreadyout_out;
   int num_errors = 0, check_count = 0;
   cmpctl_top u_dut (.*);
   cmpctl_analog_model u_analog (.clk_in(clk_sys_in), .cmp_en_in(cmp_enable_out),
      .minus_sel_in(cmp_minus_source_select_out), .amp_oe_in(amp_output_pin_oe_out),
      .plus_mv_in(plus_mv), .b6_mv_in(b6_mv), .c0_mv_in(c0_mv), .amp_level_in(amp_level),
      .cmp_raw_out(cmp_raw_in), .amp_raw_out(amp_raw_in));
   // 125 MHz system clock
   initial forever #4 clk_sys_in = !clk_sys_in;
   // ---------------------------------------------
   // Shared tasks
   // ---------------------------------------------
   task chk(input string n, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e)
      begin
         num_errors++;
         $display("BAD %s expected %h seen %h", n, e, g);
      end
   endtask
   // Single transfer; holds each phase until hready is seen high
   task bus(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
      @(posedge clk_sys_in);
      hsel_in <= 1'b1;
      htrans_in <= cmpctl_pkg::HTRANS_NONSEQ;
      haddr_in <= a;
      hwrite_in <= w;
      do @(posedge clk_sys_in); while (hready_in !== 1'b1);
      hsel_in <= 1'b0;
      htrans_in <= 2'h0;
      hwdata_in <= d;
      do @(posedge clk_sys_in); while (hready_in !== 1'b1);
      r = hrdata_out;
      chk("bus response", cmpctl_pkg::HRESP_OKAY, hresp_out);
   endtask
   task irq_count(output int n);
      n = 0;
      repeat (8)
      begin
         @(posedge clk_sys_in);
         n += int'(cmp_irq_out === 1'b1);
      end
   endtask
   // ---------------------------------------------
   // Scenarios
   // ---------------------------------------------
   task t_regs();
      logic [31:0] r;
      bus(1'b0, CTRL, 32'h0, r);
      chk("reset value", 32'h0, r & 32'hfffffffd);
      bus(1'b1, CTRL, 32'h9f, r);
      repeat (4) @(posedge clk_sys_in);
      bus(1'b0, CTRL, 32'h0, r);
      chk("all ones", 32'h9f, r);
      chk("amp enable", 1'b1, amp_enable_out);
      chk("amp drive", 1'b1, amp_output_pin_oe_out);
      chk("cmp enable", 1'b1, cmp_enable_out);
      chk("minus select", 1'b1, cmp_minus_source_select_out);
      bus(1'b1, CTRL, 32'h8f, r);
      bus(1'b1, CTRL + 32'h4, 32'h0, r);
      repeat (4) @(posedge clk_sys_in);
      bus(1'b0, CTRL, 32'h0, r);
      chk("minus from b6", 32'h8d, r);
      bus(1'b0, CTRL + 32'h4, 32'h0, r);
      chk("unmapped", 32'h0, r);
   endtask
   // Every edge select and polarity, then a disabled comparator
   task t_cmp();
      logic [31:0] r;
      int n;
      for (int k = 0; k < 5; k++)
      begin
         bus(1'b1, CTRL, k < 4 ? 32'h01 | 32'(k) << 2 : 32'h0, r);
         repeat (6) @(posedge clk_sys_in);
         plus_mv <= 16'd300;
         irq_count(n);
         chk("irq on rise", k < 4 && !k[1], n);
         chk("fault high", k < 4 && !k[0], fault_out);
         if (k < 4)
         begin
            bus(1'b0, CTRL, 32'h0, r);
            chk("cmp bit", 32'h03 | 32'(k) << 2, r);
         end
         plus_mv <= 16'd100;
         irq_count(n);
         chk("irq on fall", k < 4 && k[1], n);
         chk("fault low", k < 4 && k[0], fault_out);
      end
   endtask
   task t_amp();
      logic [31:0] r;
      // Amplifier pins stay in alternate function mode throughout
      for (int s = 0; s < 2; s++)
      begin
         port3_schmitt_en_in <= s[0];
         amp_level <= 1'b1;
         adc_chan_sel_in <= 4'h3;
         bus(1'b1, CTRL, 32'h80, r);
         repeat (5) @(posedge clk_sys_in);
         chk("port3 data", s[0], port3_amp_data_out);
         chk("port b3 source", 1'b1, portb3_irq_src_out);
         chk("channel three", 1'b1, converter_channel_three_out);
      end
      adc_chan_sel_in <= 4'h2;
      repeat (200) @(posedge clk_sys_in);
      chk("other channel", 1'b0, converter_channel_three_out);
      chk("amp still on", 1'b1, amp_enable_out);
      adc_chan_sel_in <= 4'h3;
      bus(1'b1, CTRL, 32'h0, r);
      repeat (5) @(posedge clk_sys_in);
      chk("amp released", 1'b0, amp_output_pin_oe_out);
      chk("port b3 off", 1'b0, portb3_irq_src_out);
      chk("channel off", 1'b0, converter_channel_three_out);
   endtask
   // Clock enable low freezes the block, so a write in that time is lost
   task t_freeze();
      logic [31:0] r;
      ce_in <= 1'b0;
      bus(1'b1, CTRL, 32'h80, r);
      repeat (3) @(posedge clk_sys_in);
      chk("frozen amp", 1'b0, amp_enable_out);
      ce_in <= 1'b1;
      repeat (3) @(posedge clk_sys_in);
      chk("dropped write", 1'b0, amp_output_pin_oe_out);
   endtask
   task stop_test();
      $display("Checks %0d, errors %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // Main sequence after a 12-cycle reset
   initial
   begin
      repeat (12) @(posedge clk_sys_in);
      arst_n_in <= 1'b1;
      repeat (4) @(posedge clk_sys_in);
      t_regs();
      t_cmp();
      t_amp();
      t_freeze();
      stop_test();
   end
   // Watchdog: the run needs about 420 cycles
   initial
   begin
      repeat (20000) @(posedge clk_sys_in);
      num_errors++;
      stop_test();
   end
endmodule
